//--- rtl/smsc_pkg.sv
// Purpose: shared constants and types for the serial shift core
// Assumes: one clock, mclk at 200 MHz
// Notes: per-select settings travel as one packed struct
package smsc_pkg;
  localparam int DATA_W = 16;
  localparam int FIFO_DEPTH = 8;
  localparam int NUM_CS = 2;
  localparam logic [4:0] BASE_LEN = 5'h08;
  localparam logic [3:0] MAX_EXTRA = 4'h8;
  localparam logic [7:0] DIV_RESET = 8'h00;
  localparam int CLK_MHZ = 200;
  localparam int DLY_UNIT_NS = 160;
  localparam int DLY_UNIT_CYC = (DLY_UNIT_NS * CLK_MHZ) / 1000;
  localparam logic [DATA_W-1:0] DUMMY_WORD = 16'hffff;
  // pin index in the synchroniser bank
  localparam int PIN_SCK = 0;
  localparam int PIN_MOSI = 1;
  localparam int PIN_MISO = 2;
  localparam int PIN_CS0 = 3;
  localparam int NUM_SYNC = 4;
  // status flag positions
  localparam int ST_TX_EMPTY = 0;
  localparam int ST_XFER_DONE = 1;
  localparam int ST_RX_FULL = 2;
  localparam int ST_OVR = 3;
  typedef struct packed {
    logic clock_idle_level_bit;
    logic clock_phase_bit;
    logic [3:0] extra_bits;
    logic [7:0] baud_divider;
    logic [7:0] inter_transfer_delay;
  } smsc_cs_cfg_t;
  typedef struct packed {
    logic overrun_flag;
    logic receive_full_flag;
    logic transfer_complete_flag;
    logic transmit_empty_flag;
  } smsc_status_t;
  typedef enum logic [1:0] {M_IDLE, M_SHIFT, M_DELAY} smsc_mstate_t;
endpackage : smsc_pkg

//--- rtl/smsc_core.sv
// Purpose: serial shift engine, master or slave, with transmit fifo
// Assumes: pins pass a three-flop filter; miso lags four cycles, so divider of 10 or more
// Notes: registers are plain ports; fifo feeds the transmit holding register
`timescale 1ns/1ps

// transmit word fifo
module smsc_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wptr;
  logic [AW-1:0] rptr;
  logic [AW:0] count;
  logic push;
  logic pop;

  // handshakes
  assign in_ready = (count != (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem[rptr];

  // storage
  always_ff @(posedge mclk)
  begin
    if (push)
      mem[wptr] <= in_data;
  end

  // pointers and fill level
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      wptr <= '0;
      rptr <= '0;
      count <= '0;
    end
    else
    begin
      if (push)
        wptr <= (wptr == AW'(DEPTH - 1)) ? '0 : wptr + AW'(1);
      if (pop)
        rptr <= (rptr == AW'(DEPTH - 1)) ? '0 : rptr + AW'(1);
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : smsc_fifo

// shift engine
module smsc_core (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic enable_command,
  input wire logic master_select_bit,
  input wire logic wait_read_before_transfer,
  input wire logic peripheral_select_field,
  input wire smsc_pkg::smsc_cs_cfg_t [1:0] cs_cfg,
  input wire logic [15:0] tx_data,
  input wire logic tx_valid,
  output logic tx_ready,
  input wire logic rx_read,
  input wire logic status_read,
  output logic [15:0] receive_holding_reg,
  output smsc_pkg::smsc_status_t status_reg,
  input wire logic [3:0] irq_enable,
  output logic irq,
  output logic tx_dma_req,
  output logic rx_dma_req,
  input wire logic serial_clock_pin_i,
  output logic serial_clock_pin_o,
  output logic serial_clock_pin_oe_n,
  input wire logic mosi_i,
  output logic mosi_o,
  output logic mosi_oe_n,
  input wire logic miso_i,
  output logic miso_o,
  output logic miso_oe_n,
  input wire logic chip_select_zero_i,
  output logic chip_select_zero_o,
  output logic chip_select_zero_oe_n,
  output logic chip_select_one_o,
  output logic chip_select_one_oe_n
);
  // word length minus one, 7..15
  function automatic logic [3:0] msb_idx(input logic [3:0] extra);
    logic [4:0] len;
    len = smsc_pkg::BASE_LEN + 5'((extra > smsc_pkg::MAX_EXTRA) ? smsc_pkg::MAX_EXTRA : extra);
    return 4'(len - 5'h01);
  endfunction : msb_idx

  // half period lengths; a divider of 1 is stretched to 2
  function automatic logic [7:0] half_len(input logic [7:0] div, input logic lead);
    logic [7:0] lo;
    lo = div >> 1;
    if (lo == 8'h00)
      lo = 8'h01;
    return lead ? ((div - lo == 8'h00) ? 8'h01 : div - lo) : lo;
  endfunction : half_len

  logic en;
  logic en_q;
  logic master;
  logic [3:0] s1;
  logic [3:0] s2;
  logic [3:0] s3;
  logic [3:0] f;
  logic [3:0] fp;
  smsc_pkg::smsc_mstate_t state;
  logic sel_q;
  logic sel_now;
  smsc_pkg::smsc_cs_cfg_t cfg;
  logic [3:0] msb;
  logic [7:0] hcnt;
  logic [15:0] dcnt;
  logic sclk_q;
  logic m_lead;
  logic m_trail;
  logic s_lead;
  logic s_trail;
  logic lead;
  logic trail;
  logic din;
  logic slave_sel;
  logic [15:0] sh;
  logic [15:0] next_sh;
  logic [15:0] len_mask;
  logic cap;
  logic [3:0] bitcnt;
  logic word_done;
  logic m_load;
  logic s_load;
  logic load;
  logic [15:0] hold;
  logic tx_full;
  logic [15:0] f_data;
  logic f_valid;
  logic xfer_done;
  logic rx_full;
  logic ovr;
  logic [4:0] lead_cnt;

  assign en = enable_command;
  assign master = master_select_bit;

  // pin filter: a level counts once stages two and three agree
  generate
    for (genvar i = 0; i < smsc_pkg::NUM_SYNC; i++)
    begin : g_sync
      logic pin;
      assign pin = (i == smsc_pkg::PIN_SCK) ? serial_clock_pin_i :
                   (i == smsc_pkg::PIN_MOSI) ? mosi_i :
                   (i == smsc_pkg::PIN_MISO) ? miso_i : chip_select_zero_i;
      always_ff @(posedge mclk)
      begin
        if (sys_rst)
        begin
          s1[i] <= 1'b1;
          s2[i] <= 1'b1;
          s3[i] <= 1'b1;
          f[i] <= 1'b1;
          fp[i] <= 1'b1;
        end
        else
        begin
          s1[i] <= pin;
          s2[i] <= s1[i];
          s3[i] <= s2[i];
          if (s2[i] == s3[i])
            f[i] <= s3[i];
          fp[i] <= f[i];
        end
      end
    end
  endgenerate

  // active settings: slave always uses select zero settings
  assign sel_now = (state == smsc_pkg::M_IDLE) ? peripheral_select_field : sel_q;
  assign cfg = master ? cs_cfg[sel_now] : cs_cfg[0];
  assign msb = msb_idx(cfg.extra_bits);
  assign len_mask = 16'hffff >> (4'hf - msb);

  // edge sources: divider as master, pin edges as slave
  assign m_lead = (state == smsc_pkg::M_SHIFT) && (hcnt == 8'h01) &&
                  (sclk_q == cfg.clock_idle_level_bit);
  assign m_trail = (state == smsc_pkg::M_SHIFT) && (hcnt == 8'h01) &&
                   (sclk_q != cfg.clock_idle_level_bit);
  assign slave_sel = en && !master && !f[smsc_pkg::PIN_CS0];
  assign s_lead = slave_sel && (f[smsc_pkg::PIN_SCK] != fp[smsc_pkg::PIN_SCK]) &&
                  (fp[smsc_pkg::PIN_SCK] == cfg.clock_idle_level_bit);
  assign s_trail = slave_sel && (f[smsc_pkg::PIN_SCK] != fp[smsc_pkg::PIN_SCK]) &&
                   (fp[smsc_pkg::PIN_SCK] != cfg.clock_idle_level_bit);
  assign lead = master ? m_lead : s_lead;
  assign trail = master ? m_trail : s_trail;
  assign din = master ? f[smsc_pkg::PIN_MISO] : f[smsc_pkg::PIN_MOSI];
  assign word_done = trail && (bitcnt == msb);

  // load conditions
  assign m_load = en && master && (state == smsc_pkg::M_IDLE) && tx_full &&
                  !(wait_read_before_transfer && rx_full) &&
                  (cfg.baud_divider != smsc_pkg::DIV_RESET);
  assign s_load = slave_sel && ((fp[smsc_pkg::PIN_CS0] && !f[smsc_pkg::PIN_CS0]) || word_done);
  assign load = m_load || s_load;
  assign next_sh = {sh[14:0], cfg.clock_phase_bit ? cap : din};

  // master sequencer
  always_ff @(posedge mclk)
  begin
    if (sys_rst || !en || !master)
    begin
      state <= smsc_pkg::M_IDLE;
      hcnt <= 8'h00;
      dcnt <= 16'h0000;
      sel_q <= 1'b0;
    end
    else
    begin
      case (state)
        smsc_pkg::M_IDLE:
        begin
          if (m_load)
          begin
            state <= smsc_pkg::M_SHIFT;
            sel_q <= peripheral_select_field;
            hcnt <= half_len(cfg.baud_divider, 1'b1);
          end
        end
        smsc_pkg::M_SHIFT:
        begin
          if (word_done)
          begin
            if (cfg.inter_transfer_delay != 8'h00)
            begin
              state <= smsc_pkg::M_DELAY;
              dcnt <= 16'(cfg.inter_transfer_delay * smsc_pkg::DLY_UNIT_CYC);
            end
            else
              state <= smsc_pkg::M_IDLE;
          end
          else if (hcnt == 8'h01)
            hcnt <= half_len(cfg.baud_divider, sclk_q != cfg.clock_idle_level_bit);
          else
            hcnt <= hcnt - 8'h01;
        end
        smsc_pkg::M_DELAY:
        begin
          if (dcnt <= 16'h0001)
            state <= smsc_pkg::M_IDLE;
          else
            dcnt <= dcnt - 16'h0001;
        end
        default:
          state <= smsc_pkg::M_IDLE;
      endcase
    end
  end

  // serial clock, one pulse per bit
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
      sclk_q <= 1'b0;
    else if (state != smsc_pkg::M_SHIFT)
      sclk_q <= cfg.clock_idle_level_bit;
    else if (m_lead || m_trail)
      sclk_q <= !sclk_q;
  end

  // shift register and bit counter
  always_ff @(posedge mclk)
  begin
    if (sys_rst || !en)
    begin
      sh <= 16'h0000;
      cap <= 1'b0;
      bitcnt <= 4'h0;
      mosi_o <= 1'b1;
      miso_o <= 1'b1;
    end
    else if (load)
    begin
      sh <= tx_full ? hold : smsc_pkg::DUMMY_WORD;
      bitcnt <= 4'h0;
      if (cfg.clock_phase_bit)
      begin
        mosi_o <= tx_full ? hold[msb] : 1'b1;
        miso_o <= tx_full ? hold[msb] : 1'b1;
      end
    end
    else if (lead)
    begin
      if (cfg.clock_phase_bit)
        cap <= din;
      else
      begin
        mosi_o <= sh[msb];
        miso_o <= sh[msb];
      end
    end
    else if (trail)
    begin
      sh <= next_sh;
      bitcnt <= bitcnt + 4'h1;
      if (cfg.clock_phase_bit)
      begin
        mosi_o <= sh[msb - 4'h1];
        miso_o <= sh[msb - 4'h1];
      end
    end
  end

  // transmit fifo in front of the holding register
  smsc_fifo #(
    .WIDTH(smsc_pkg::DATA_W),
    .DEPTH(smsc_pkg::FIFO_DEPTH)
  ) u_fifo (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .in_data(tx_data),
    .in_valid(tx_valid),
    .in_ready(tx_ready),
    .out_data(f_data),
    .out_valid(f_valid),
    .out_ready(en && !tx_full)
  );

  // transmit holding register
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      hold <= 16'h0000;
      tx_full <= 1'b0;
    end
    else if (load && tx_full)
      tx_full <= 1'b0;
    else if (en && f_valid && !tx_full)
    begin
      hold <= f_data;
      tx_full <= 1'b1;
    end
  end

  // transfer-complete flag
  always_ff @(posedge mclk)
  begin
    en_q <= sys_rst ? 1'b0 : en;
    if (sys_rst || !en)
      xfer_done <= 1'b0;
    else if (!en_q)
      xfer_done <= 1'b1;
    else if (load && tx_full)
      xfer_done <= 1'b0;
    else if (master && !tx_full && ((state == smsc_pkg::M_DELAY && dcnt <= 16'h0001) ||
             (word_done && cfg.inter_transfer_delay == 8'h00)))
      xfer_done <= 1'b1;
    else if (!master && word_done && !tx_full)
      xfer_done <= 1'b1;
  end

  // receive register, full and overrun; a set beats a same-cycle clear
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      receive_holding_reg <= 16'h0000;
      rx_full <= 1'b0;
      ovr <= 1'b0;
    end
    else
    begin
      if (word_done)
      begin
        receive_holding_reg <= next_sh & len_mask;
        rx_full <= 1'b1;
      end
      else if (rx_read)
        rx_full <= 1'b0;
      if (word_done && rx_full && !rx_read)
        ovr <= 1'b1;
      else if (status_read)
        ovr <= 1'b0;
    end
  end

  // status, dma and interrupt
  assign status_reg = '{overrun_flag: ovr, receive_full_flag: rx_full,
                        transfer_complete_flag: xfer_done, transmit_empty_flag: en_q && !tx_full};
  assign tx_dma_req = status_reg.transmit_empty_flag;
  assign rx_dma_req = rx_full;
  always_ff @(posedge mclk)
  begin
    irq <= sys_rst ? 1'b0 : |(status_reg & irq_enable);
  end

  // pin drive; enable low means driving
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      chip_select_zero_o <= 1'b1;
      chip_select_one_o <= 1'b1;
      serial_clock_pin_oe_n <= 1'b1;
      mosi_oe_n <= 1'b1;
      miso_oe_n <= 1'b1;
      chip_select_zero_oe_n <= 1'b1;
      chip_select_one_oe_n <= 1'b1;
    end
    else
    begin
      chip_select_zero_o <= !((m_load && !peripheral_select_field) ||
                              (state == smsc_pkg::M_SHIFT && !word_done && !sel_q));
      chip_select_one_o <= !((m_load && peripheral_select_field) ||
                             (state == smsc_pkg::M_SHIFT && !word_done && sel_q));
      serial_clock_pin_oe_n <= !(en && master);
      mosi_oe_n <= !(en && master);
      chip_select_zero_oe_n <= !(en && master);
      chip_select_one_oe_n <= !(en && master);
      miso_oe_n <= !slave_sel;
    end
  end
  assign serial_clock_pin_o = sclk_q;

  // leading edges seen in the current word
  always_ff @(posedge mclk)
  begin
    if (sys_rst || load)
      lead_cnt <= 5'h00;
    else if (lead)
      lead_cnt <= lead_cnt + 5'h01;
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  sequence s_word_end;
    word_done ##1 rx_full;
  endsequence
  sequence s_load_master;
    m_load ##1 (state == smsc_pkg::M_SHIFT);
  endsequence

  load_starts_a: assert property (m_load |-> s_load_master)
    else $error("load did not start a transfer");
  tx_empty_load_a: assert property (m_load |=> status_reg.transmit_empty_flag)
    else $error("transmit empty not set after load");
  enable_flags_a: assert property ($rose(en) |=> ##1 (xfer_done && !(tx_full && !en_q)))
    else $error("enable did not set flags");
  rx_full_set_a: assert property (word_done |-> s_word_end)
    else $error("receive full not set");
  overrun_set_a: assert property (word_done && rx_full && !rx_read |=> ovr)
    else $error("overrun not flagged");
  pulse_count_a: assert property (word_done && master |-> lead_cnt == 5'(msb) + 5'h01)
    else $error("clock pulse count differs from word length");
  wait_read_a: assert property (wait_read_before_transfer && rx_full &&
                                state == smsc_pkg::M_IDLE |=> state == smsc_pkg::M_IDLE &&
                                chip_select_zero_o && chip_select_one_o)
    else $error("transfer started before receive read");
  div_zero_a: assert property (cfg.baud_divider == 8'h00 &&
                               state == smsc_pkg::M_IDLE |=> state == smsc_pkg::M_IDLE)
    else $error("transfer started with zero divider");
  cs_idle_a: assert property (state == smsc_pkg::M_IDLE && !m_load ##1 !m_load
                              |-> chip_select_zero_o && chip_select_one_o)
    else $error("chip select low outside a transfer");
  irq_follow_a: assert property (|(status_reg & irq_enable) |=> irq)
    else $error("interrupt missing for enabled flag");
endmodule : smsc_core

//--- dv/smsc_slave_model.sv
// Purpose: behavioural serial slave on the far side of the shift core
// Assumes: selected by a low select line, settings matching the master
// Notes: released miso shows the inverse of the last bit driven
`timescale 1ns/1ps

module smsc_slave_model (
  input wire logic sck,
  input wire logic cs_n,
  input wire logic mosi,
  input wire logic idle_lvl,
  input wire logic cpha,
  input wire logic [4:0] nbits,
  input wire logic [15:0] tx_word,
  output logic miso,
  output logic [15:0] rx_word
);
  int k;
  logic last;
  wire cs_d;

  // select seen 100 ps late, so a last edge that meets the select rise still counts
  assign #0.1 cs_d = cs_n;

  // present the next answer bit
  task drive;
    begin
      miso = tx_word[nbits - 1 - k];
      last = miso;
      k++;
    end
  endtask : drive

  // start values
  initial
  begin
    miso = 1'b0;
    last = 1'b0;
    k = 0;
    rx_word = '0;
  end

  // deselected: line released, not holding its last value
  always @(posedge cs_d)
    miso = ~last;

  // frame start, phase 1 shows the msb before the first edge
  always @(negedge cs_d)
  begin
    k = 0;
    rx_word = '0;
    if (cpha)
      drive();
  end

  // capture and shift edges picked by phase
  always @(sck)
    if (!cs_d)
    begin
      if ((sck != idle_lvl) == cpha)
        rx_word = {rx_word[14:0], mosi};
      else if (k < nbits)
        drive();
    end
endmodule : smsc_slave_model

//--- dv/smsc_core_bench.sv
// Purpose: self-checking bench for the serial shift core
// Assumes: mclk 5 ns, slave model on select zero
// Notes: each scenario is one task that judges its own results
`timescale 1ns/1ps

module smsc_core_bench;
  logic mclk, sys_rst, enable_command, master_select_bit, wait_read_before_transfer;
  logic peripheral_select_field, tx_valid, tx_ready, rx_read, status_read, irq;
  logic tx_dma_req, rx_dma_req, tb_sck, tb_mosi, tb_cs0, p_miso, sck, cs0, prev_sck, prev_cs;
  smsc_pkg::smsc_cs_cfg_t [1:0] cs_cfg;
  smsc_pkg::smsc_status_t status_reg;
  logic [15:0] tx_data, receive_holding_reg, psw, prx;
  logic [3:0] irq_enable;
  logic serial_clock_pin_i, serial_clock_pin_o, serial_clock_pin_oe_n, mosi_i, mosi_o;
  logic mosi_oe_n, miso_i, miso_o, miso_oe_n, chip_select_zero_i, chip_select_zero_o;
  logic chip_select_zero_oe_n, chip_select_one_o, chip_select_one_oe_n;
  int err_total = 0, n_tests = 0, pulses = 0, act = 0, words = 0;

  // pin levels from all drivers
  assign sck = serial_clock_pin_oe_n ? tb_sck : serial_clock_pin_o;
  assign serial_clock_pin_i = sck;
  assign cs0 = chip_select_zero_oe_n ? tb_cs0 : chip_select_zero_o;
  assign chip_select_zero_i = cs0;
  assign mosi_i = mosi_oe_n ? tb_mosi : mosi_o;
  assign miso_i = miso_oe_n ? p_miso : miso_o;

  smsc_core smsc_core_inst (.mclk, .sys_rst, .enable_command, .master_select_bit,
    .wait_read_before_transfer, .peripheral_select_field, .cs_cfg, .tx_data, .tx_valid,
    .tx_ready, .rx_read, .status_read, .receive_holding_reg, .status_reg, .irq_enable, .irq,
    .tx_dma_req, .rx_dma_req, .serial_clock_pin_i, .serial_clock_pin_o, .serial_clock_pin_oe_n,
    .mosi_i, .mosi_o, .mosi_oe_n, .miso_i, .miso_o, .miso_oe_n, .chip_select_zero_i,
    .chip_select_zero_o, .chip_select_zero_oe_n, .chip_select_one_o, .chip_select_one_oe_n);

  smsc_slave_model smsc_slave_model_inst (.sck(sck), .cs_n(cs0 | ~master_select_bit),
    .mosi(mosi_i), .idle_lvl(cs_cfg[0].clock_idle_level_bit), .cpha(cs_cfg[0].clock_phase_bit),
    .nbits(5'h08 + {1'b0, cs_cfg[0].extra_bits}), .tx_word(psw), .miso(p_miso),
    .rx_word(prx));

  // clock
  always #2.5 mclk = ~mclk;

  // count clock pulses, active half cycles and frames on select zero
  always @(posedge mclk)
  begin
    if (!cs0 && sck !== cs_cfg[0].clock_idle_level_bit)
    begin
      act++;
      if (prev_sck === cs_cfg[0].clock_idle_level_bit)
        pulses++;
    end
    if (!cs0 && prev_cs)
      words++;
    prev_sck = sck;
    prev_cs = cs0;
  end

  function automatic smsc_pkg::smsc_cs_cfg_t mk(input logic cp, ph, input logic [3:0] ex,
                                                 input logic [7:0] dv, dl);
    return {cp, ph, ex, dv, dl};
  endfunction : mk

  task chk_val(input logic [15:0] g, e, input string s);
    begin
      n_tests++;
      if (g !== e)
      begin
        err_total++;
        $display("wrong value at %0t: %s got %h exp %h", $time, s, g, e);
      end
    end
  endtask : chk_val

  task chk_num(input int g, e, input string s);
    begin
      n_tests++;
      if (g != e)
      begin
        err_total++;
        $display("wrong value at %0t: %s got %0d exp %0d", $time, s, g, e);
      end
    end
  endtask : chk_num

  task conclude;
    begin
      $display("checks %0d errors %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0)
        $display("All tests passed");
      else
        $display("Some tests failed");
      $finish;
    end
  endtask : conclude

  // one word through the valid/ready write port
  task push(input logic [15:0] d);
    int i;
    begin
      @(posedge mclk);
      tx_data <= d;
      tx_valid <= 1'b1;
      for (i = 0; i < 50; i++)
      begin
        @(negedge mclk);
        if (tx_ready === 1'b1)
          break;
      end
      @(posedge mclk);
      tx_valid <= 1'b0;
    end
  endtask : push

  // read strobe: 0 receive register, 1 status
  task pulse(input logic st);
    begin
      @(posedge mclk);
      rx_read <= ~st;
      status_read <= st;
      @(posedge mclk);
      rx_read <= 1'b0;
      status_read <= 1'b0;
      repeat (3) @(negedge mclk);
    end
  endtask : pulse

  task wait_cs0(input logic want, input int lim);
    int i;
    begin
      for (i = 0; i < lim && cs0 !== want; i++)
        @(negedge mclk);
      chk_val(cs0, want, "select wait");
    end
  endtask : wait_cs0

  task xfer(input logic cp, ph, input logic [3:0] ex, input logic [7:0] dv, dl,
            input logic [15:0] d, sw);
    int n;
    logic [15:0] m;
    begin
      n = 8 + ex;
      m = 16'hffff >> (16 - n);
      @(posedge mclk);
      cs_cfg[0] <= mk(cp, ph, ex, dv, dl);
      psw <= sw;
      repeat (3) @(negedge mclk);
      pulses = 0;
      act = 0;
      push(d);
      wait_cs0(1'b0, 100);
      wait_cs0(1'b1, 1000);
      chk_num(pulses, n, "pulses");
      chk_num(act, n * dv / 2, "active half");
      chk_val(prx & m, d & m, "mosi word");
      repeat (4) @(negedge mclk);
      chk_val(receive_holding_reg, sw & m, "rx word");
      chk_val({status_reg.receive_full_flag, rx_dma_req}, 2'h3, "rx full");
      chk_val(sck, cp, "idle level");
      if (dl != 8'h00)
      begin
        chk_val(status_reg.transfer_complete_flag, 1'b0, "early done");
        repeat (dl * smsc_pkg::DLY_UNIT_CYC + 10) @(negedge mclk);
      end
      chk_val(status_reg.transfer_complete_flag, 1'b1, "done");
      pulse(1'b0);
      chk_val(status_reg.receive_full_flag, 1'b0, "rx cleared");
    end
  endtask : xfer

  task sel_one;
    int i;
    begin
      @(posedge mclk);
      peripheral_select_field <= 1'b1;
      cs_cfg[1] <= mk(1'b1, 1'b0, 4'h0, 8'h08, 8'h00);
      push(16'h0033);
      for (i = 0; i < 100 && chip_select_one_o !== 1'b0; i++)
        @(negedge mclk);
      chk_val({chip_select_one_o, cs0, sck}, 3'h3, "select one");
      for (i = 0; i < 1000 && chip_select_one_o !== 1'b1; i++)
        @(negedge mclk);
      chk_val(chip_select_one_o, 1'b1, "select one end");
      @(posedge mclk);
      peripheral_select_field <= 1'b0;
      pulse(1'b0);
    end
  endtask : sel_one

  task fill_drain;
    int i;
    begin
      @(posedge mclk);
      cs_cfg[0] <= mk(1'b0, 1'b1, 4'h0, 8'h00, 8'h00);
      psw <= 16'h005a;
      @(negedge mclk);
      words = 0;
      for (i = 1; i <= 9; i++)
        push(16'(i));
      @(negedge mclk);
      chk_val({tx_ready, tx_dma_req, cs0}, 3'h1, "full, idle");
      @(posedge mclk);
      cs_cfg[0].baud_divider <= 8'h0c;
      for (i = 0; i < 3000 && !(words == 9 && status_reg.transfer_complete_flag === 1'b1); i++)
        @(negedge mclk);
      chk_num(words, 9, "frames");
      chk_val(prx, 16'h0009, "last word");
      chk_val(receive_holding_reg, 16'h005a, "rx kept");
      chk_val(status_reg, 4'hf, "overrun");
      @(posedge mclk);
      irq_enable <= 4'h8;
      repeat (3) @(negedge mclk);
      chk_val(irq, 1'b1, "irq overrun");
      pulse(1'b1);
      chk_val({status_reg.overrun_flag, irq}, 2'h0, "overrun cleared");
      @(posedge mclk);
      irq_enable <= 4'h0;
    end
  endtask : fill_drain

  task wait_read;
    begin
      @(posedge mclk);
      wait_read_before_transfer <= 1'b1;
      push(16'h00a7);
      repeat (100) @(negedge mclk);
      chk_val(cs0, 1'b1, "held for read");
      pulse(1'b0);
      wait_cs0(1'b0, 100);
      wait_cs0(1'b1, 1000);
      @(posedge mclk);
      wait_read_before_transfer <= 1'b0;
      pulse(1'b0);
    end
  endtask : wait_read

  task slave_xfer;
    int i;
    logic [7:0] got, sd;
    begin
      sd = 8'ha5;
      @(posedge mclk);
      master_select_bit <= 1'b0;
      cs_cfg[0] <= mk(1'b0, 1'b1, 4'h0, 8'h08, 8'h00);
      push(16'h00c3);
      repeat (4) @(negedge mclk);
      chk_val({chip_select_one_oe_n, serial_clock_pin_oe_n, mosi_oe_n, miso_oe_n}, 4'hf,
              "slave released");
      @(posedge mclk);
      tb_cs0 <= 1'b0;
      repeat (8) @(posedge mclk);
      chk_val(miso_oe_n, 1'b0, "slave drives");
      for (i = 7; i >= 0; i--)
      begin
        tb_mosi <= sd[i];
        repeat (8) @(posedge mclk);
        tb_sck <= 1'b1;
        got[i] = miso_o;
        repeat (8) @(posedge mclk);
        tb_sck <= 1'b0;
      end
      repeat (8) @(posedge mclk);
      tb_cs0 <= 1'b1;
      repeat (8) @(negedge mclk);
      chk_val(got, 8'hc3, "slave out");
      chk_val(receive_holding_reg, 16'h00a5, "slave in");
      chk_val(miso_oe_n, 1'b1, "slave release");
    end
  endtask : slave_xfer

  // watchdog
  initial
  begin
    repeat (40000) @(posedge mclk);
    err_total++;
    conclude;
  end

  // main sequence
  initial
  begin
    mclk = 1'b0;
    sys_rst = 1'b1;
    enable_command = 1'b0;
    master_select_bit = 1'b1;
    wait_read_before_transfer = 1'b0;
    peripheral_select_field = 1'b0;
    cs_cfg[0] = mk(1'b0, 1'b1, 4'h0, 8'h08, 8'h00);
    cs_cfg[1] = mk(1'b0, 1'b1, 4'h0, 8'h08, 8'h00);
    tx_data = 16'h0000;
    tx_valid = 1'b0;
    rx_read = 1'b0;
    status_read = 1'b0;
    irq_enable = 4'h0;
    tb_sck = 1'b0;
    tb_mosi = 1'b1;
    tb_cs0 = 1'b1;
    psw = 16'h0000;
    repeat (20) @(posedge mclk);
    sys_rst <= 1'b0;
    repeat (4) @(negedge mclk);
    chk_val({chip_select_zero_o, chip_select_one_o, chip_select_zero_oe_n, status_reg}, 7'h70,
            "reset");
    @(posedge mclk);
    enable_command <= 1'b1;
    repeat (4) @(negedge mclk);
    chk_val(status_reg, 4'h3, "enable flags");
    chk_val({tx_dma_req, rx_dma_req, irq}, 3'h4, "dma and irq");
    chk_val({chip_select_zero_oe_n, chip_select_one_oe_n, serial_clock_pin_oe_n, mosi_oe_n,
             miso_oe_n}, 5'h01, "master pins");
    @(posedge mclk);
    irq_enable <= 4'h1;
    repeat (3) @(negedge mclk);
    chk_val(irq, 1'b1, "irq empty");
    @(posedge mclk);
    irq_enable <= 4'h0;
    xfer(1'b0, 1'b1, 4'h0, 8'h0c, 8'h00, 16'h0096, 16'h0069);
    xfer(1'b0, 1'b0, 4'h1, 8'h0c, 8'h00, 16'h01a5, 16'h015a);
    xfer(1'b1, 1'b1, 4'h4, 8'h0c, 8'h00, 16'h0bcd, 16'h0432);
    xfer(1'b1, 1'b0, 4'h8, 8'h0c, 8'h01, 16'hbeef, 16'h1234);
    sel_one;
    fill_drain;
    wait_read;
    slave_xfer;
    conclude;
  end
endmodule : smsc_core_bench
